// ==== ctm_defs.vh ====
`ifndef CTM_DEFS_VH
`define CTM_DEFS_VH

// Register byte offsets
`define CTM_ADR_CTRL      5'h00
`define CTM_ADR_MODE      5'h04
`define CTM_ADR_OUTCTL    5'h08
`define CTM_ADR_MASK      5'h0C
`define CTM_ADR_LOWCMP    5'h10
`define CTM_ADR_HIGHCMP   5'h14
`define CTM_ADR_STATUS    5'h18

// Control register fields
`define CTM_CTRL_RUN      0
`define CTM_CTRL_TOS      1
`define CTM_CTRL_CS_LO    2
`define CTM_CTRL_CS_HI    3
`define CTM_CTRL_EXT      4

// Mode register fields
`define CTM_MODE_MS_LO    0
`define CTM_MODE_MS_HI    1
`define CTM_MODE_DC_LO    2
`define CTM_MODE_DC_HI    3

// Output control fields
`define CTM_OC_OS_LO      0
`define CTM_OC_OS_HI      2
`define CTM_OC_PRESET     3

// Compare action mask fields
`define CTM_MK_RST        0
`define CTM_MK_TGL_CM     1
`define CTM_MK_IRQ_CM     2
`define CTM_MK_TGL_OVF    3
`define CTM_MK_IRQ_OVF    4

// Status fields
`define CTM_ST_LOW_LO     0
`define CTM_ST_LOW_HI     3
`define CTM_ST_HIGH_LO    4
`define CTM_ST_HIGH_HI    11
`define CTM_ST_TFF        12
`define CTM_ST_MOD        13
`define CTM_ST_PIN        14

// Reset values
`define CTM_RST_CTRL      5'h00
`define CTM_RST_MODE      4'hF
`define CTM_RST_OUTCTL    4'hF
`define CTM_RST_MASK      5'h00
`define CTM_RST_LOWCMP    4'h0
`define CTM_RST_HIGHCMP   8'h00
`define CTM_RST_RUN       1'b0
`define CTM_RST_MS        2'h3
`define CTM_RST_DC        2'h3
`define CTM_RST_OS        3'h7

// Clock select codes
`define CTM_CS_SYS        2'h0
`define CTM_CS_ITV        2'h1
`define CTM_CS_SHIFT      2'h2

// Counter modes
`define CTM_M_CASCADE     2'h3
`define CTM_M_PRESCALE    2'h2
`define CTM_M_INDEP_RUN   2'h1
`define CTM_M_INDEP_STOP  2'h0

// Duty cycle codes
`define CTM_DC_BYPASS     2'h3
`define CTM_DC_DIV2       2'h2
`define CTM_DC_DIV3       2'h1
`define CTM_DC_DIV4       2'h0

// Output modes
`define CTM_OM_TOGGLE     3'h7
`define CTM_OM_BURST_TFF  3'h6
`define CTM_OM_BURST_SO   3'h5
`define CTM_OM_BIPHASE    3'h4
`define CTM_OM_MANCH      3'h3
`define CTM_OM_SSI        3'h2
`define CTM_OM_PWM        3'h1

// Counter limits and values, zero read data
`define CTM_LOW_MAX       4'hF
`define CTM_HIGH_MAX      8'hFF
`define CTM_LOW_ZERO      4'h0
`define CTM_HIGH_ZERO     8'h00
`define CTM_DCG_ZERO      2'h0
`define CTM_DCG_ONE       2'h1
`define CTM_DCG_TWO       2'h2
`define CTM_DCG_THREE     2'h3
`define CTM_RD_ZERO       32'h00000000

`endif

// ==== ctm_partner.sv ====
// Pin clock source; stands low between bursts, phase unrelated to clk_in
module ctm_partner (
  input  wire       start_in,
  input  wire [7:0] count_in,
  output logic      ext_count_clock_out
);
  timeunit 1ns;
  timeprecision 100ps;
  initial ext_count_clock_out = 1'b0;
  always @(posedge start_in) begin
    repeat (count_in) begin
      #28 ext_count_clock_out = 1'b1;
      #28 ext_count_clock_out = 1'b0;
    end
  end
endmodule // ctm_partner

// ==== ctm_timer.v ====
// Added by the designer: the Avalon-MM register port and the register addresses.
`include "ctm_defs.vh"

// Functional notes
// [R01] Four-bit and eight-bit up counters with compares
// [R02] Clock from system, pin, interval, shift
// [R03] Pin clock counts unsynchronised to system; here it is synchronised through ext_s1_q to ext_s3_q and counted on clk_in
// [R04] Pin clock keeps counting during sleep
// [R05] Four-bit stage drives prescaler clock output
// [R06] Compare value x gives x+1 counts
// [R07] Mask selects reset, toggle, interrupt actions
// [R08] Mode 1 cascades twelve-bit compare counter
// [R09] Mode 1: output from overflow, duty bypassed
// [R10] Mode 2 prescales; duty 25/33/50 percent
// [R11] Mode 2: prescaler output from low match
// [R12] Modes 3/4 independent; pin clock allowed
// [R13] Mode 3 runs prescaler, mode 4 clears
// [R14] Toggle mode inverts flip-flop on match
// [R15] Toggle on start inverts at timer start
// [R16] Overflow also toggles when enabled
// [R17] Burst modes gate duty output to pin
// [R18] Modulator starts/stops with shifter or match
// [R19] Low stage stops modulator at bit count
// [R20] Low stage plus duty form carrier prescaler
// [R21] Bi-phase and Manchester encoding of data
// [R22] Clock select 00 sys, 01 interval, 10 shift
// [R23] Run clear stops and resets counters
// [R24] Pulse width: first match per period only
// [R25] Match on equality, restart when enabled
// [R26] Interrupt on match/overflow when mask allows
module ctm_timer (
  input  wire        clk_in,
  input  wire        rst_n_in,
  input  wire        ce_in,
  input  wire [4:0]  avs_address_in,
  input  wire        avs_read_in,
  input  wire        avs_write_in,
  input  wire [31:0] avs_writedata_in,
  output reg  [31:0] avs_readdata_out,
  output reg         avs_waitrequest_out,
  input  wire        ext_count_clock_in,
  input  wire        interval_timer_out_in,
  input  wire        shift_clock_in,
  input  wire        shifter_run_flag_in,
  input  wire        serial_data_in,
  input  wire        sleep_in,
  output reg         timer_output_pin_out,
  output reg         prescaler_clock_out,
  output reg         duty_gen_output_out,
  output reg         timer_irq_out
);

  function rise;
    input prev;
    input cur;
    begin
      rise = cur & ~prev;
    end
  endfunction

  function [1:0] dcg_top;
    input [1:0] code;
    begin
      case (code)
        `CTM_DC_DIV2: dcg_top = `CTM_DCG_ONE;
        `CTM_DC_DIV3: dcg_top = `CTM_DCG_TWO;
        `CTM_DC_DIV4: dcg_top = `CTM_DCG_THREE;
        default:      dcg_top = `CTM_DCG_ZERO;
      endcase
    end
  endfunction

  // Software settings
  reg        run_q;
  reg        tos_q;
  reg [1:0]  clk_sel_q;
  reg        ext_hi_q;
  reg [1:0]  mode_q;
  reg [1:0]  duty_q;
  reg        preset_q;
  reg [2:0]  osel_q;
  reg [4:0]  mask_q;
  reg [3:0]  low_cmp_q;
  reg [7:0]  high_cmp_q;

  // Counting state
  reg [3:0]  low_q;
  reg [3:0]  low_d;
  reg [7:0]  high_q;
  reg [7:0]  high_d;
  reg [1:0]  dcg_cnt_q;
  reg [1:0]  dcg_cnt_d;
  reg        tff_q;
  reg        tff_d;
  reg        pwm_arm_q;
  reg        pwm_arm_d;

  // Modulator state
  reg        mod_act_q;
  reg        mod_act_d;
  reg        half_q;
  reg        half_d;
  reg        biph_q;
  reg        biph_d;
  reg        sir_prev_q;

  // Source edge tracking
  reg        ext_s1_q;
  reg        ext_s2_q;
  reg        ext_s3_q;
  reg        itv_prev_q;
  reg        shc_prev_q;

  // Bus read data, pin and duty levels
  reg [31:0] rdata_d;
  reg        pin_d;
  reg        dcg_lvl;

  wire       req        = avs_read_in | avs_write_in;
  wire       wr_acc     = avs_write_in & ~avs_waitrequest_out;
  wire       wr_ctrl    = wr_acc & (avs_address_in == `CTM_ADR_CTRL);
  wire       wr_mode    = wr_acc & (avs_address_in == `CTM_ADR_MODE);
  wire       wr_outctl  = wr_acc & (avs_address_in == `CTM_ADR_OUTCTL);
  wire       wr_mask    = wr_acc & (avs_address_in == `CTM_ADR_MASK);
  wire       wr_lowcmp  = wr_acc & (avs_address_in == `CTM_ADR_LOWCMP);
  wire       wr_highcmp = wr_acc & (avs_address_in == `CTM_ADR_HIGHCMP);

  // Clock sources; all but the pin clock are stopped while the oscillator sleeps
  wire       itv_tick = rise(itv_prev_q, interval_timer_out_in);
  wire       shc_tick = rise(shc_prev_q, shift_clock_in);
  // Pin clock edge; only the second and third stages are looked at
  wire       ext_tick = rise(ext_s3_q, ext_s2_q);
  reg        src_tick;

  always @* begin
    case (clk_sel_q) // [R02] [R22]
      `CTM_CS_SYS:   src_tick = ~sleep_in; // [R04]
      `CTM_CS_ITV:   src_tick = itv_tick & ~sleep_in; // [R04]
      `CTM_CS_SHIFT: src_tick = shc_tick & ~sleep_in; // [R04]
      default:       src_tick = 1'b0;
    endcase
  end

  wire       is_casc  = (mode_q == `CTM_M_CASCADE);
  wire       is_pre   = (mode_q == `CTM_M_PRESCALE);
  wire       is_indep = (mode_q == `CTM_M_INDEP_RUN) | (mode_q == `CTM_M_INDEP_STOP);
  wire       low_en   = run_q & (mode_q != `CTM_M_INDEP_STOP); // [R13] [R23]
  wire       low_tick = low_en & src_tick;
  wire       low_hit  = (low_q == low_cmp_q);
  wire       low_ovf  = low_tick & (low_q == `CTM_LOW_MAX); // [R05]
  wire       low_match = low_tick & low_hit & ~is_casc; // [R06] [R25]

  // Pin clock reaches the high stage only in the independent modes
  wire       hi_src   = (is_indep & ext_hi_q) ? ext_tick : src_tick; // [R03] [R04] [R12]
  wire [1:0] duty_eff = is_casc ? `CTM_DC_BYPASS : duty_q; // [R09]
  wire       dcg_byp  = (duty_eff == `CTM_DC_BYPASS);
  wire       dcg_in   = run_q & (is_pre ? low_match : hi_src); // [R10] [R20]
  wire       dcg_last = (dcg_cnt_q == dcg_top(duty_eff));
  wire       dcg_tick = dcg_in & (dcg_byp | dcg_last); // [R10]
  wire       hi_tick  = is_casc ? low_ovf : dcg_tick; // [R08]
  wire       high_hit = (high_q == high_cmp_q);

  // Stage two match: both halves agree in the cascaded mode
  wire       st2_match = is_casc ? (low_tick & low_hit & high_hit)
                                 : (hi_tick & high_hit); // [R08] [R25]
  wire       st2_ovf   = hi_tick & (high_q == `CTM_HIGH_MAX);
  wire       rst_match = st2_match & mask_q[`CTM_MK_RST]; // [R07] [R25]
  wire       is_pwm    = (osel_q == `CTM_OM_PWM);
  wire       tgl_match = st2_match & mask_q[`CTM_MK_TGL_CM]
                         & (~is_pwm | pwm_arm_q); // [R14] [R24]
  wire       tgl_ovf   = st2_ovf & mask_q[`CTM_MK_TGL_OVF]; // [R16]
  wire       run_start = wr_ctrl & avs_writedata_in[`CTM_CTRL_RUN] & ~run_q;
  wire       tgl_start = run_start & avs_writedata_in[`CTM_CTRL_TOS]; // [R15]
  wire       irq_d     = (st2_match & mask_q[`CTM_MK_IRQ_CM])
                         | (st2_ovf & mask_q[`CTM_MK_IRQ_OVF]); // [R26]

  // Modulator start and stop
  wire       sir_fall  = sir_prev_q & ~shifter_run_flag_in;
  wire       sir_rise  = ~sir_prev_q & shifter_run_flag_in;
  wire       cm_stop   = low_match & (mode_q == `CTM_M_INDEP_RUN)
                         & (clk_sel_q == `CTM_CS_SHIFT); // [R19]
  wire       half_evt  = mod_act_q & st2_match;

  always @* begin
    low_d = low_q;
    if (!low_en) begin
      low_d = `CTM_LOW_ZERO; // [R13] [R23]
    end else if (low_tick) begin
      if (low_match | (is_casc & rst_match)) begin
        low_d = `CTM_LOW_ZERO; // [R06]
      end else begin
        low_d = low_q + 4'h1; // [R01]
      end
    end
  end

  always @* begin
    high_d = high_q;
    if (!run_q) begin
      high_d = `CTM_HIGH_ZERO; // [R23]
    end else if (rst_match) begin
      high_d = `CTM_HIGH_ZERO; // [R25]
    end else if (hi_tick) begin
      high_d = high_q + 8'h01; // [R01]
    end
  end

  always @* begin
    dcg_cnt_d = dcg_cnt_q;
    if (!run_q || dcg_byp) begin
      dcg_cnt_d = `CTM_DCG_ZERO;
    end else if (dcg_in) begin
      dcg_cnt_d = dcg_last ? `CTM_DCG_ZERO : dcg_cnt_q + 2'h1;
    end
    // High for one of two, three or four input periods
    dcg_lvl = dcg_byp ? dcg_in : (run_q & (dcg_cnt_q == `CTM_DCG_ZERO)); // [R10]
  end

  always @* begin
    tff_d = tff_q;
    if (wr_outctl && !run_q) begin
      tff_d = avs_writedata_in[`CTM_OC_PRESET];
    end else begin
      tff_d = tff_q ^ tgl_match ^ tgl_ovf ^ tgl_start; // [R14] [R15] [R16]
    end
    pwm_arm_d = pwm_arm_q;
    if (!run_q || st2_ovf) begin
      pwm_arm_d = 1'b1; // [R24]
    end else if (tgl_match && is_pwm) begin
      pwm_arm_d = 1'b0; // [R24]
    end
  end

  always @* begin
    mod_act_d = mod_act_q;
    half_d    = half_q;
    biph_d    = biph_q;
    if (sir_fall) begin
      mod_act_d = 1'b1; // [R18]
      half_d    = 1'b0;
      biph_d    = 1'b0;
    end else if (sir_rise || cm_stop) begin
      mod_act_d = 1'b0; // [R18] [R19]
    end else if (half_evt) begin
      half_d = ~half_q;
      // Bi-phase: edge at every bit start, extra mid-bit edge for a zero
      if (half_q || !serial_data_in) begin
        biph_d = ~biph_q; // [R21]
      end
    end
  end

  always @* begin
    case (osel_q)
      `CTM_OM_TOGGLE:    pin_d = tff_q; // [R14]
      `CTM_OM_PWM:       pin_d = tff_q; // [R24]
      `CTM_OM_BURST_TFF: pin_d = dcg_lvl & tff_q; // [R17] [R20]
      `CTM_OM_BURST_SO:  pin_d = dcg_lvl & serial_data_in & mod_act_q; // [R17]
      `CTM_OM_BIPHASE:   pin_d = biph_q & mod_act_q; // [R21]
      `CTM_OM_MANCH:     pin_d = (serial_data_in ^ half_q) & mod_act_q; // [R21]
      `CTM_OM_SSI:       pin_d = serial_data_in;
      default:           pin_d = 1'b0;
    endcase
  end

  always @* begin
    rdata_d = `CTM_RD_ZERO;
    case (avs_address_in)
      `CTM_ADR_CTRL: begin
        rdata_d[`CTM_CTRL_RUN] = run_q;
        rdata_d[`CTM_CTRL_TOS] = tos_q;
        rdata_d[`CTM_CTRL_CS_HI:`CTM_CTRL_CS_LO] = clk_sel_q;
        rdata_d[`CTM_CTRL_EXT] = ext_hi_q;
      end
      `CTM_ADR_MODE: begin
        rdata_d[`CTM_MODE_MS_HI:`CTM_MODE_MS_LO] = mode_q;
        rdata_d[`CTM_MODE_DC_HI:`CTM_MODE_DC_LO] = duty_q;
      end
      `CTM_ADR_OUTCTL: begin
        rdata_d[`CTM_OC_OS_HI:`CTM_OC_OS_LO] = osel_q;
        rdata_d[`CTM_OC_PRESET] = preset_q;
      end
      `CTM_ADR_MASK: begin
        rdata_d[`CTM_MK_IRQ_OVF:`CTM_MK_RST] = mask_q;
      end
      `CTM_ADR_LOWCMP: begin
        rdata_d[`CTM_ST_LOW_HI:`CTM_ST_LOW_LO] = low_cmp_q;
      end
      `CTM_ADR_HIGHCMP: begin
        rdata_d[`CTM_ST_HIGH_HI - `CTM_ST_HIGH_LO:0] = high_cmp_q;
      end
      `CTM_ADR_STATUS: begin
        rdata_d[`CTM_ST_LOW_HI:`CTM_ST_LOW_LO] = low_q;
        rdata_d[`CTM_ST_HIGH_HI:`CTM_ST_HIGH_LO] = high_q;
        rdata_d[`CTM_ST_TFF] = tff_q;
        rdata_d[`CTM_ST_MOD] = mod_act_q;
        rdata_d[`CTM_ST_PIN] = timer_output_pin_out;
      end
      default: begin
        rdata_d = `CTM_RD_ZERO;
      end
    endcase
  end

  // Bus slave: one wait state, answer at the second edge
  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      avs_waitrequest_out <= 1'b1;
      avs_readdata_out    <= `CTM_RD_ZERO;
    end else if (ce_in) begin
      avs_waitrequest_out <= ~(req & avs_waitrequest_out);
      if (avs_read_in && avs_waitrequest_out) begin
        avs_readdata_out <= rdata_d;
      end
    end
  end

  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      run_q      <= `CTM_RST_RUN;
      tos_q      <= 1'b0;
      clk_sel_q  <= `CTM_CS_SYS;
      ext_hi_q   <= 1'b0;
      mode_q     <= `CTM_RST_MS;
      duty_q     <= `CTM_RST_DC;
      osel_q     <= `CTM_RST_OS;
      preset_q   <= 1'b1;
      mask_q     <= `CTM_RST_MASK;
      low_cmp_q  <= `CTM_RST_LOWCMP;
      high_cmp_q <= `CTM_RST_HIGHCMP;
    end else if (ce_in) begin
      if (wr_ctrl) begin
        run_q     <= avs_writedata_in[`CTM_CTRL_RUN]; // [R23]
        tos_q     <= avs_writedata_in[`CTM_CTRL_TOS];
        clk_sel_q <= avs_writedata_in[`CTM_CTRL_CS_HI:`CTM_CTRL_CS_LO];
        ext_hi_q  <= avs_writedata_in[`CTM_CTRL_EXT];
      end
      if (wr_mode) begin
        mode_q <= avs_writedata_in[`CTM_MODE_MS_HI:`CTM_MODE_MS_LO];
        duty_q <= avs_writedata_in[`CTM_MODE_DC_HI:`CTM_MODE_DC_LO];
      end
      if (wr_outctl) begin
        osel_q   <= avs_writedata_in[`CTM_OC_OS_HI:`CTM_OC_OS_LO];
        preset_q <= avs_writedata_in[`CTM_OC_PRESET];
      end
      if (wr_mask) begin
        mask_q <= avs_writedata_in[`CTM_MK_IRQ_OVF:`CTM_MK_RST]; // [R07]
      end
      if (wr_lowcmp) begin
        low_cmp_q <= avs_writedata_in[`CTM_ST_LOW_HI:`CTM_ST_LOW_LO];
      end
      if (wr_highcmp) begin
        high_cmp_q <= avs_writedata_in[`CTM_ST_HIGH_HI - `CTM_ST_HIGH_LO:0];
      end
    end
  end

  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      low_q     <= `CTM_LOW_ZERO;
      high_q    <= `CTM_HIGH_ZERO;
      dcg_cnt_q <= `CTM_DCG_ZERO;
      tff_q     <= 1'b1;
      pwm_arm_q <= 1'b1;
      mod_act_q <= 1'b0;
      half_q    <= 1'b0;
      biph_q    <= 1'b0;
    end else if (ce_in) begin
      low_q     <= low_d;
      high_q    <= high_d;
      dcg_cnt_q <= dcg_cnt_d;
      tff_q     <= tff_d;
      pwm_arm_q <= pwm_arm_d;
      mod_act_q <= mod_act_d;
      half_q    <= half_d;
      biph_q    <= biph_d;
    end
  end

  // Pin clock crosses two flops first, so it cannot outrun clk_in
  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      ext_s1_q   <= 1'b0;
      ext_s2_q   <= 1'b0;
      ext_s3_q   <= 1'b0;
      itv_prev_q <= 1'b0;
      shc_prev_q <= 1'b0;
      sir_prev_q <= 1'b1;
    end else if (ce_in) begin
      ext_s1_q   <= ext_count_clock_in;
      ext_s2_q   <= ext_s1_q;
      ext_s3_q   <= ext_s2_q;
      itv_prev_q <= interval_timer_out_in;
      shc_prev_q <= shift_clock_in;
      sir_prev_q <= shifter_run_flag_in;
    end
  end

  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      timer_output_pin_out <= 1'b0;
      prescaler_clock_out  <= 1'b0;
      duty_gen_output_out  <= 1'b0;
      timer_irq_out        <= 1'b0;
    end else if (ce_in) begin
      timer_output_pin_out <= pin_d;
      prescaler_clock_out  <= is_casc ? low_ovf : low_match; // [R05] [R09] [R11]
      duty_gen_output_out  <= dcg_lvl;
      timer_irq_out        <= irq_d; // [R26]
    end
  end

endmodule // ctm_timer

// ==== ctm_timer_asserts.sv ====
module ctm_timer_asserts (
  input wire        clk_in,
  input wire        rst_n_in,
  input wire        ce_in,
  input wire [4:0]  avs_address_in,
  input wire        avs_read_in,
  input wire        avs_write_in,
  input wire [31:0] avs_writedata_in,
  input wire [31:0] avs_readdata_out,
  input wire        avs_waitrequest_out,
  input wire        ext_count_clock_in,
  input wire        interval_timer_out_in,
  input wire        shift_clock_in,
  input wire        shifter_run_flag_in,
  input wire        serial_data_in,
  input wire        sleep_in,
  input wire        timer_output_pin_out,
  input wire        prescaler_clock_out,
  input wire        duty_gen_output_out,
  input wire        timer_irq_out
);
  timeunit 1ns;
  timeprecision 100ps;
  // Shadow copies of the settings, taken at the bus commit edge
  logic [4:0] ctrl_q;
  logic [4:0] mask_q;
  logic [1:0] mode_q;
  logic [3:0] low_q;
  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      ctrl_q <= 5'h00;
      mask_q <= 5'h00;
      mode_q <= 2'h3;
      low_q  <= 4'h0;
    end else if (ce_in && avs_write_in && !avs_waitrequest_out) begin
      case (avs_address_in)
        5'h00: ctrl_q <= avs_writedata_in[4:0];
        5'h04: mode_q <= avs_writedata_in[1:0];
        5'h0C: mask_q <= avs_writedata_in[4:0];
        5'h10: low_q <= avs_writedata_in[3:0];
        default: ;
      endcase
    end
  end
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_n_in);
  sequence s_req;
    (avs_read_in || avs_write_in) && avs_waitrequest_out;
  endsequence
  sequence s_ans;
    !avs_waitrequest_out ##1 avs_waitrequest_out;
  endsequence
  a_bus_answer: assert property (s_req |=> s_ans)
    else $error("bus answer not one cycle");
  a_bus_cause: assert property ($fell(avs_waitrequest_out) |-> $past(avs_read_in) || $past(avs_write_in))
    else $error("bus answer without request");
  a_unmapped_zero: assert property (avs_read_in && !avs_waitrequest_out && avs_address_in == 5'h1C
    |-> avs_readdata_out == 32'h00000000) else $error("unmapped read not zero");
  a_upper_zero: assert property (avs_read_in && !avs_waitrequest_out
    |-> avs_readdata_out[31:15] == 17'h00000) else $error("upper read bits set");
  a_reset_quiet: assert property (disable iff (1'b0) !rst_n_in |=> avs_waitrequest_out
    && !timer_output_pin_out && !timer_irq_out && !prescaler_clock_out && !duty_gen_output_out)
    else $error("outputs active after reset");
  a_irq_masked: assert property (timer_irq_out |-> $past(mask_q[2]) || $past(mask_q[4]))
    else $error("interrupt while masked");
  a_stop_quiet: assert property (!ctrl_q[0] && !$past(ctrl_q[0]) && !$past(ctrl_q[0], 2)
    |-> !timer_irq_out) else $error("interrupt while stopped");
  a_mode4_quiet: assert property (mode_q == 2'h0 && $past(mode_q) == 2'h0
    && $past(mode_q, 2) == 2'h0 && low_q != 4'h0 |-> !prescaler_clock_out)
    else $error("prescaler runs in mode 4");
  a_sleep_freeze: assert property (sleep_in && $past(sleep_in) && $past(sleep_in, 2)
    && !ctrl_q[4] && !$past(ctrl_q[4], 2) |-> !timer_irq_out) else $error("count during sleep");
endmodule // ctm_timer_asserts

bind ctm_timer ctm_timer_asserts u_chk (.*);

// ==== ctm_timer_tb.sv ====
module ctm_timer_tb;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct {logic wr; logic [4:0] a; logic [31:0] d; logic [31:0] e;} ctm_row_t;
  logic        clk_in = 1'b0;
  logic        rst_n_in = 1'b0;
  logic        ce_in = 1'b1;
  logic        avs_read_in = 1'b0;
  logic        avs_write_in = 1'b0;
  logic [4:0]  avs_address_in = 5'h00;
  logic [31:0] avs_writedata_in = 32'h00000000;
  logic        interval_timer_out_in = 1'b0;
  logic        shift_clock_in = 1'b0;
  logic        shifter_run_flag_in = 1'b1;
  logic        serial_data_in = 1'b0;
  logic        sleep_in = 1'b0;
  logic        go = 1'b0;
  logic [1:0]  div_q = 2'h0;
  logic [31:0] q;
  int          num_errors = 0;
  int          checks_done = 0;
  wire         ext_count_clock_in;
  wire [31:0]  avs_readdata_out;
  wire         avs_waitrequest_out;
  wire         timer_output_pin_out;
  wire         prescaler_clock_out;
  wire         duty_gen_output_out;
  wire         timer_irq_out;
  ctm_row_t rows [14] = '{'{0, 5'h00, 0, 32'h0}, '{0, 5'h04, 0, 32'hF}, '{0, 5'h08, 0, 32'hF},
    '{0, 5'h0C, 0, 32'h0}, '{0, 5'h10, 0, 32'h0}, '{0, 5'h14, 0, 32'h0}, '{0, 5'h18, 0, 32'h5000},
    '{1, 5'h00, 32'hFFFFFFFE, 32'h1E}, '{1, 5'h04, 32'hFFFFFFF6, 32'h6}, '{1, 5'h08, 5, 5},
    '{1, 5'h0C, 32'hFFFFFFFF, 32'h1F}, '{1, 5'h10, 32'hAB, 32'hB}, '{1, 5'h14, 32'h1A5, 32'hA5},
    '{1, 5'h1C, 32'h55, 32'h0}};
  // Clock select, compare value, cycles between pin edges
  int per [4][3] = '{'{0, 0, 1}, '{0, 2, 3}, '{1, 2, 6}, '{2, 1, 8}};
  ctm_timer DUT (.*);
  ctm_partner u_src (.start_in(go), .count_in(8'h14), .ext_count_clock_out(ext_count_clock_in));
  always #4 clk_in = !clk_in;
  always @(posedge clk_in) begin
    div_q <= div_q + 2'h1;
    interval_timer_out_in <= div_q[0];
    shift_clock_in <= div_q[1];
  end
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d,
                     output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge clk_in);
    avs_address_in <= a;
    avs_writedata_in <= d;
    avs_write_in <= wr;
    avs_read_in <= !wr;
    do begin
      @(posedge clk_in);
      n++;
    end while (avs_waitrequest_out !== 1'b0 && n < 100);
    rd = avs_readdata_out;
    avs_read_in <= 1'b0;
    avs_write_in <= 1'b0;
    if (n >= 100) num_errors++;
  endtask
  task automatic wreg(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] rd;
    bus(1'b1, a, d, rd);
  endtask
  task automatic edge_gap(output int n);
    logic p;
    p = timer_output_pin_out;
    n = 0;
    do begin
      @(posedge clk_in);
      n++;
    end while (timer_output_pin_out === p && n < 600);
  endtask
  // First two gaps skipped: start-up latency is not a period
  task automatic period(input int exp);
    int n;
    repeat (3) edge_gap(n);
    chk("pin period", exp, n);
  endtask
  task automatic pulses(input logic [1:0] sel, input int cyc, input int exp, input string name);
    int n;
    n = 0;
    repeat (cyc) begin
      @(posedge clk_in);
      n += ((sel == 2'h2) ? (duty_gen_output_out === 1'b1)
            : ((sel[0] ? prescaler_clock_out : timer_irq_out) === 1'b1));
    end
    chk(name, exp, n);
  endtask
  task automatic end_of_test();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    #200000;
    num_errors++;
    end_of_test();
  end
  initial begin
    repeat (2) @(posedge clk_in);
    rst_n_in <= 1'b1;
    foreach (rows[i]) begin
      if (rows[i].wr) wreg(rows[i].a, rows[i].d);
      bus(1'b0, rows[i].a, 32'h0, q);
      chk("register", rows[i].e, q);
    end
    wreg(5'h04, 32'hD);
    wreg(5'h0C, 32'h3);
    wreg(5'h08, 32'h7);
    foreach (per[i]) begin
      wreg(5'h00, 32'h0);
      wreg(5'h14, per[i][1]);
      wreg(5'h00, 32'h1 | (per[i][0] << 2));
      period(per[i][2]);
    end
    wreg(5'h00, 32'h0);
    wreg(5'h14, 32'h4);
    wreg(5'h10, 32'h3);
    wreg(5'h0C, 32'h7);
    wreg(5'h00, 32'h1);
    repeat (10) @(posedge clk_in);
    pulses(1'b0, 50, 10, "irq count");
    pulses(1'b1, 40, 10, "prescaler count");
    wreg(5'h04, 32'hC);
    repeat (5) @(posedge clk_in);
    pulses(1'b1, 40, 0, "prescaler stopped");
    period(5);
    wreg(5'h0C, 32'h3);
    repeat (5) @(posedge clk_in);
    pulses(1'b0, 50, 0, "irq masked");
    wreg(5'h00, 32'h0);
    bus(1'b0, 5'h18, 32'h0, q);
    chk("counts after stop", 32'h0, q & 32'hFFF);
    wreg(5'h0C, 32'h0);
    wreg(5'h08, 32'hF);
    repeat (3) @(posedge clk_in);
    chk("preset pin", 32'h1, timer_output_pin_out);
    wreg(5'h00, 32'h3);
    repeat (3) @(posedge clk_in);
    chk("start toggle", 32'h0, timer_output_pin_out);
    wreg(5'h00, 32'h0);
    wreg(5'h04, 32'hF);
    wreg(5'h10, 32'h1);
    wreg(5'h14, 32'h1);
    wreg(5'h0C, 32'h3);
    wreg(5'h00, 32'h1);
    period(18);
    pulses(1, 36, 2, "cascade prescaler");
    wreg(5'h00, 32'h0);
    wreg(5'h04, 32'hA);
    wreg(5'h14, 32'h0);
    wreg(5'h00, 32'h1);
    period(4);
    pulses(1, 40, 20, "prescale output");
    pulses(2, 40, 20, "duty output");
    wreg(5'h00, 32'h0);
    wreg(5'h04, 32'hD);
    wreg(5'h14, 32'h7F);
    wreg(5'h0C, 32'hA);
    wreg(5'h08, 32'h1);
    wreg(5'h00, 32'h1);
    period(128);
    wreg(5'h00, 32'h0);
    wreg(5'h14, 32'h3);
    wreg(5'h0C, 32'h1);
    wreg(5'h08, 32'h3);
    serial_data_in <= 1'b1;
    wreg(5'h00, 32'h1);
    shifter_run_flag_in <= 1'b0;
    period(4);
    shifter_run_flag_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    bus(1'b0, 5'h18, 32'h0, q);
    chk("modulator stop", 32'h0, q & 32'h6000);
    wreg(5'h00, 32'h0);
    wreg(5'h10, 32'hF);
    wreg(5'h00, 32'h9);
    shifter_run_flag_in <= 1'b0;
    bus(1'b0, 5'h18, 32'h0, q);
    chk("modulator running", 32'h2000, q & 32'h2000);
    repeat (80) @(posedge clk_in);
    bus(1'b0, 5'h18, 32'h0, q);
    chk("bit count stop", 32'h0, q & 32'h2000);
    wreg(5'h00, 32'h0);
    wreg(5'h14, 32'hFF);
    wreg(5'h04, 32'hD);
    wreg(5'h0C, 32'h14);
    sleep_in <= 1'b1;
    wreg(5'h00, 32'h11);
    go <= 1'b1;
    repeat (200) @(posedge clk_in);
    bus(1'b0, 5'h18, 32'h0, q);
    chk("pin clock count", 32'h14, (q >> 4) & 32'hFF);
    wreg(5'h00, 32'h0);
    wreg(5'h00, 32'h1);
    repeat (30) @(posedge clk_in);
    bus(1'b0, 5'h18, 32'h0, q);
    chk("sleep count", 32'h0, q & 32'hFFF);
    sleep_in <= 1'b0;
    end_of_test();
  end
endmodule // ctm_timer_tb
